/* File: hw/analog_monitor_scaling.sv */
`include "monitor_scaling_regs.svh"
`default_nettype none

module analog_monitor_scaling (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Drive quantities, same clock domain
  input wire monitor_scaling_pkg::drive_quantities_type quantities,
  // Converter codes towards the monitor connector
  output monitor_scaling_pkg::monitor_codes_type monitor_output_connector
);

  // Channel parameters
  logic [15:0] monitor_one_select_ff;
  logic [15:0] monitor_two_select_ff;
  logic [15:0] monitor_one_offset_ff;
  logic [15:0] monitor_two_offset_ff;
  logic [15:0] monitor_one_gain_ff;
  logic [15:0] monitor_two_gain_ff;
  logic [15:0] nxt_monitor_one_select;
  logic [15:0] nxt_monitor_two_select;
  logic [15:0] nxt_monitor_one_offset;
  logic [15:0] nxt_monitor_two_offset;
  logic [15:0] nxt_monitor_one_gain;
  logic [15:0] nxt_monitor_two_gain;

  // Bus answer
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic [31:0] nxt_prdata;
  logic nxt_pslverr;

  // Scaled signals
  logic signed [31:0] sig_one_ff;
  logic signed [31:0] sig_two_ff;
  logic signed [31:0] nxt_sig_one;
  logic signed [31:0] nxt_sig_two;

  logic signed [15:0] code_one;
  logic signed [15:0] code_two;
  logic setup_phase;
  logic write_strobe;

  // Limit a setting to +-10000
  function automatic logic [15:0] clamp_param(input logic [15:0] v);
    if (signed'(v) > signed'(`MON_PARAM_MAX)) begin
      return `MON_PARAM_MAX;
    end else if (signed'(v) < signed'(`MON_PARAM_MIN)) begin
      return `MON_PARAM_MIN;
    end
    return v;
  endfunction

  // Selected quantity in millivolts
  function automatic logic signed [31:0] scale_quantity(
    input logic [15:0] sel,
    input monitor_scaling_pkg::drive_quantities_type q
  );
    logic signed [31:0] mv;
    mv = '0;
    case (sel[`SEL_FIELD_MSB:`SEL_FIELD_LSB])
      monitor_scaling_pkg::SEL_MOTOR_SPEED: begin
        mv = 32'(q.motor_speed);
      end
      monitor_scaling_pkg::SEL_SPEED_REF: begin
        mv = 32'(q.speed_ref);
      end
      monitor_scaling_pkg::SEL_TORQUE_REF: begin
        mv = 32'(q.torque_ref);
      end
      monitor_scaling_pkg::SEL_POS_DEV: begin
        if (q.control_mode == monitor_scaling_pkg::CTRL_POSITION) begin
          mv = 32'(q.pos_deviation) * signed'(`MV_PER_POS_UNIT);
        end
      end
      monitor_scaling_pkg::SEL_AMP_DEV: begin
        mv = 32'(q.amp_deviation) * signed'(`MV_PER_POS_UNIT);
      end
      monitor_scaling_pkg::SEL_POS_CMD_SPEED: begin
        mv = 32'(q.pos_cmd_speed);
      end
      monitor_scaling_pkg::SEL_LOAD_DEV: begin
        mv = 32'(q.load_deviation) * signed'(`MV_PER_LOAD_UNIT);
      end
      monitor_scaling_pkg::SEL_POS_DONE: begin
        mv = q.positioning_done ? signed'(`MV_COMPLETE) : '0;
      end
      monitor_scaling_pkg::SEL_SPEED_FF: begin
        mv = 32'(q.speed_ff);
      end
      monitor_scaling_pkg::SEL_TORQUE_FF: begin
        mv = 32'(q.torque_ff);
      end
      monitor_scaling_pkg::SEL_ACTIVE_GAIN: begin
        mv = q.second_gain_active ? signed'(`MV_SECOND_GAIN) :
             signed'(`MV_FIRST_GAIN);
      end
      monitor_scaling_pkg::SEL_DISTRIB_DONE: begin
        mv = q.distribution_done ? signed'(`MV_COMPLETE) : '0;
      end
      monitor_scaling_pkg::SEL_EXT_ENC_SPEED: begin
        mv = 32'(q.ext_enc_speed);
      end
      default: begin
        mv = '0;
      end
    endcase
    return mv;
  endfunction

  // APB phase decode, always zero wait states
  assign setup_phase = psel && !penable;
  assign write_strobe = psel && penable && pwrite;
  assign pready = 1'b1;

  // Parameter writes take effect at the access edge
  always_comb begin
    nxt_monitor_one_select = monitor_one_select_ff;
    nxt_monitor_two_select = monitor_two_select_ff;
    nxt_monitor_one_offset = monitor_one_offset_ff;
    nxt_monitor_two_offset = monitor_two_offset_ff;
    nxt_monitor_one_gain = monitor_one_gain_ff;
    nxt_monitor_two_gain = monitor_two_gain_ff;
    if (write_strobe) begin
      case (paddr)
        `ADDR_MON1_SEL: nxt_monitor_one_select = pwdata[15:0];
        `ADDR_MON2_SEL: nxt_monitor_two_select = pwdata[15:0];
        `ADDR_MON1_OFS: nxt_monitor_one_offset = clamp_param(pwdata[15:0]);
        `ADDR_MON2_OFS: nxt_monitor_two_offset = clamp_param(pwdata[15:0]);
        `ADDR_MON1_GAIN: nxt_monitor_one_gain = clamp_param(pwdata[15:0]);
        `ADDR_MON2_GAIN: nxt_monitor_two_gain = clamp_param(pwdata[15:0]);
        default: begin
        end
      endcase
    end
  end

  // Parameter registers with documented defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      monitor_one_select_ff <= `MON1_SEL_RESET;
      monitor_two_select_ff <= `MON2_SEL_RESET;
      monitor_one_offset_ff <= `MON_OFS_RESET;
      monitor_two_offset_ff <= `MON_OFS_RESET;
      monitor_one_gain_ff <= `MON_GAIN_RESET;
      monitor_two_gain_ff <= `MON_GAIN_RESET;
    end else begin
      monitor_one_select_ff <= nxt_monitor_one_select;
      monitor_two_select_ff <= nxt_monitor_two_select;
      monitor_one_offset_ff <= nxt_monitor_one_offset;
      monitor_two_offset_ff <= nxt_monitor_two_offset;
      monitor_one_gain_ff <= nxt_monitor_one_gain;
      monitor_two_gain_ff <= nxt_monitor_two_gain;
    end
  end

  // Read data and error captured in the setup cycle
  always_comb begin
    nxt_prdata = prdata_ff;
    nxt_pslverr = pslverr_ff;
    if (setup_phase) begin
      nxt_prdata = '0;
      nxt_pslverr = 1'b0;
      case (paddr)
        `ADDR_MON1_SEL: nxt_prdata = {16'h0000, monitor_one_select_ff};
        `ADDR_MON2_SEL: nxt_prdata = {16'h0000, monitor_two_select_ff};
        `ADDR_MON1_OFS: nxt_prdata = {16'h0000, monitor_one_offset_ff};
        `ADDR_MON2_OFS: nxt_prdata = {16'h0000, monitor_two_offset_ff};
        `ADDR_MON1_GAIN: nxt_prdata = {16'h0000, monitor_one_gain_ff};
        `ADDR_MON2_GAIN: nxt_prdata = {16'h0000, monitor_two_gain_ff};
        `ADDR_MON1_CODE: begin
          nxt_prdata = {16'h0000, code_one};
          nxt_pslverr = pwrite;
        end
        `ADDR_MON2_CODE: begin
          nxt_prdata = {16'h0000, code_two};
          nxt_pslverr = pwrite;
        end
        default: nxt_pslverr = 1'b1;
      endcase
      if (pwrite) begin
        nxt_prdata = '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= '0;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff && psel && penable;

  // Per-channel quantity selection and scaling
  always_comb begin
    nxt_sig_one = scale_quantity(monitor_one_select_ff, quantities);
    nxt_sig_two = scale_quantity(monitor_two_select_ff, quantities);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sig_one_ff <= '0;
      sig_two_ff <= '0;
    end else begin
      sig_one_ff <= nxt_sig_one;
      sig_two_ff <= nxt_sig_two;
    end
  end

  // Magnification, offset and clipping per channel
  monitor_channel u_channel_one (
    .pclk(pclk),
    .presetn(presetn),
    .sig_mv(sig_one_ff),
    .gain(monitor_one_gain_ff),
    .offset(monitor_one_offset_ff),
    .code(code_one)
  );

  monitor_channel u_channel_two (
    .pclk(pclk),
    .presetn(presetn),
    .sig_mv(sig_two_ff),
    .gain(monitor_two_gain_ff),
    .offset(monitor_two_offset_ff),
    .code(code_two)
  );

  assign monitor_output_connector.ch_one = code_one;
  assign monitor_output_connector.ch_two = code_two;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_CH_INDEPENDENT: assert property (
    (write_strobe && paddr == `ADDR_MON1_SEL) |=> $stable(monitor_two_select_ff))
    else $error("channel one select write disturbed channel two");

  AST_SPEED_SCALE: assert property (
    (monitor_one_select_ff[7:0] == monitor_scaling_pkg::SEL_MOTOR_SPEED)
    |=> sig_one_ff == 32'($past(quantities.motor_speed)))
    else $error("motor speed not at 1 mV per unit");

  AST_TORQUE_SCALE: assert property (
    (monitor_two_select_ff[7:0] == monitor_scaling_pkg::SEL_TORQUE_FF)
    |=> sig_two_ff == 32'($past(quantities.torque_ff)))
    else $error("torque feedforward scale wrong");

  AST_POSDEV_BLOCKED: assert property (
    (monitor_two_select_ff[7:0] == monitor_scaling_pkg::SEL_POS_DEV &&
     quantities.control_mode != monitor_scaling_pkg::CTRL_POSITION)
    |=> sig_two_ff == 32'sh0000_0000)
    else $error("position deviation shown outside position control");

  AST_AMPDEV_SCALE: assert property (
    (monitor_one_select_ff[7:0] == monitor_scaling_pkg::SEL_AMP_DEV)
    |=> sig_one_ff == 32'($past(quantities.amp_deviation)) * 32'sh0000_0032)
    else $error("amplifier deviation not 50 mV per pulse");

  AST_LOADDEV_SCALE: assert property (
    (monitor_two_select_ff[7:0] == monitor_scaling_pkg::SEL_LOAD_DEV)
    |=> sig_two_ff == 32'($past(quantities.load_deviation)) * 32'sh0000_000A)
    else $error("load deviation not 10 mV per unit");

  AST_POS_DONE_LEVEL: assert property (
    (monitor_one_select_ff[7:0] == monitor_scaling_pkg::SEL_POS_DONE)
    |=> sig_one_ff == ($past(quantities.positioning_done) ?
                       32'sh0000_1388 : 32'sh0000_0000))
    else $error("positioning completion level wrong");

  AST_ACTIVE_GAIN: assert property (
    (monitor_two_select_ff[7:0] == monitor_scaling_pkg::SEL_ACTIVE_GAIN)
    |=> sig_two_ff == ($past(quantities.second_gain_active) ?
                       32'sh0000_07D0 : 32'sh0000_03E8))
    else $error("active gain level wrong");

  AST_DISTRIB_LEVEL: assert property (
    (monitor_one_select_ff[7:0] == monitor_scaling_pkg::SEL_DISTRIB_DONE)
    |=> sig_one_ff == ($past(quantities.distribution_done) ?
                       32'sh0000_1388 : 32'sh0000_0000))
    else $error("distribution completion level wrong");

  AST_EXT_ENC_SCALE: assert property (
    (monitor_two_select_ff[7:0] == monitor_scaling_pkg::SEL_EXT_ENC_SPEED)
    |=> sig_two_ff == 32'($past(quantities.ext_enc_speed)))
    else $error("external encoder speed scale wrong");

  AST_RESERVED_ZERO: assert property (
    (monitor_one_select_ff[7:0] == monitor_scaling_pkg::SEL_RESERVED ||
     monitor_one_select_ff[7:0] > monitor_scaling_pkg::SEL_EXT_ENC_SPEED)
    |=> sig_one_ff == 32'sh0000_0000)
    else $error("reserved code produced a signal");

  AST_OFFSET_CLAMP: assert property (
    (write_strobe && paddr == `ADDR_MON1_OFS &&
     signed'(pwdata[15:0]) > signed'(`MON_PARAM_MAX))
    |=> monitor_one_offset_ff == `MON_PARAM_MAX)
    else $error("offset above range not clamped");

  AST_GAIN_WRITE: assert property (
    (write_strobe && paddr == `ADDR_MON2_GAIN &&
     signed'(pwdata[15:0]) <= signed'(`MON_PARAM_MAX) &&
     signed'(pwdata[15:0]) >= signed'(`MON_PARAM_MIN))
    |=> monitor_two_gain_ff == $past(pwdata[15:0]))
    else $error("gain write not taken at once");

endmodule

`default_nettype wire

/* File: hw/monitor_scaling_regs.svh */
`ifndef MONITOR_SCALING_REGS_SVH
`define MONITOR_SCALING_REGS_SVH

// Register byte addresses
`define ADDR_MON1_SEL 12'h000
`define ADDR_MON2_SEL 12'h004
`define ADDR_MON1_OFS 12'h008
`define ADDR_MON2_OFS 12'h00C
`define ADDR_MON1_GAIN 12'h010
`define ADDR_MON2_GAIN 12'h014
`define ADDR_MON1_CODE 12'h018
`define ADDR_MON2_CODE 12'h01C

// Field positions
`define SEL_FIELD_MSB 7
`define SEL_FIELD_LSB 0
`define PARAM_MSB 15

// Reset values
`define MON1_SEL_RESET 16'h0002
`define MON2_SEL_RESET 16'h0000
`define MON_OFS_RESET 16'h0000
`define MON_GAIN_RESET 16'h0064

// Setting limits, +-10000
`define MON_PARAM_MAX 16'h2710
`define MON_PARAM_MIN 16'hD8F0

// Signal scales in millivolts
`define MV_PER_POS_UNIT 32'h0000_0032
`define MV_PER_LOAD_UNIT 32'h0000_000A
`define MV_COMPLETE 32'h0000_1388
`define MV_FIRST_GAIN 32'h0000_03E8
`define MV_SECOND_GAIN 32'h0000_07D0

// Output arithmetic
`define GAIN_DIVISOR 48'h0000_0000_0064
`define MV_PER_OFS_STEP 48'h0000_0000_0064
`define DAC_CODE_MAX 16'h7FFF
`define DAC_CODE_MIN 16'h8000

`endif

/* File: hw/monitor_scaling_pkg.sv */
`default_nettype none

package monitor_scaling_pkg;

  // Drive control mode
  typedef enum logic [1:0] {
    CTRL_POSITION = 2'h0,
    CTRL_SPEED = 2'h1,
    CTRL_TORQUE = 2'h3
  } control_mode_type;

  // Monitor selection codes, low two digits of the parameter
  typedef enum logic [7:0] {
    SEL_MOTOR_SPEED = 8'h00,
    SEL_SPEED_REF = 8'h01,
    SEL_TORQUE_REF = 8'h02,
    SEL_POS_DEV = 8'h03,
    SEL_AMP_DEV = 8'h04,
    SEL_POS_CMD_SPEED = 8'h05,
    SEL_RESERVED = 8'h06,
    SEL_LOAD_DEV = 8'h07,
    SEL_POS_DONE = 8'h08,
    SEL_SPEED_FF = 8'h09,
    SEL_TORQUE_FF = 8'h0A,
    SEL_ACTIVE_GAIN = 8'h0B,
    SEL_DISTRIB_DONE = 8'h0C,
    SEL_EXT_ENC_SPEED = 8'h0D
  } monitor_select_type;

  // Internal quantities of the drive
  typedef struct packed {
    logic signed [15:0] motor_speed;
    logic signed [15:0] speed_ref;
    logic signed [15:0] torque_ref;
    logic signed [15:0] pos_deviation;
    logic signed [15:0] amp_deviation;
    logic signed [15:0] pos_cmd_speed;
    logic signed [15:0] load_deviation;
    logic signed [15:0] speed_ff;
    logic signed [15:0] torque_ff;
    logic signed [15:0] ext_enc_speed;
    logic positioning_done;
    logic second_gain_active;
    logic distribution_done;
    control_mode_type control_mode;
  } drive_quantities_type;

  // Converter codes, one millivolt per step
  typedef struct packed {
    logic signed [15:0] ch_one;
    logic signed [15:0] ch_two;
  } monitor_codes_type;

endpackage

`default_nettype wire

/* File: hw/monitor_channel.sv */
`include "monitor_scaling_regs.svh"
`default_nettype none

module monitor_channel (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Scaled signal and channel settings
  input wire logic signed [31:0] sig_mv,
  input wire logic [15:0] gain,
  input wire logic [15:0] offset,
  // Converter code
  output logic signed [15:0] code
);

  logic signed [15:0] code_ff;
  logic signed [15:0] nxt_code;
  logic signed [47:0] prod;
  logic signed [47:0] scaled;
  logic signed [47:0] ofs_mv;
  logic signed [47:0] sum;

  // Clip to converter range instead of wrapping
  function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
    if (v > 48'(signed'(`DAC_CODE_MAX))) begin
      return signed'(`DAC_CODE_MAX);
    end else if (v < 48'(signed'(`DAC_CODE_MIN))) begin
      return signed'(`DAC_CODE_MIN);
    end
    return v[15:0];
  endfunction

  // Inverted, magnified and shifted signal
  always_comb begin
    prod = 48'(sig_mv) * 48'(signed'(gain));
    scaled = -(prod / signed'(`GAIN_DIVISOR));
    ofs_mv = 48'(signed'(offset)) * signed'(`MV_PER_OFS_STEP);
    sum = scaled + ofs_mv;
    nxt_code = sat16(sum);
  end

  // Output register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_ff <= '0;
    end else begin
      code_ff <= nxt_code;
    end
  end

  assign code = code_ff;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_UNITY_PATH: assert property (
    (gain == `MON_GAIN_RESET && offset == `MON_OFS_RESET &&
     sig_mv > 32'shFFFF_FC18 && sig_mv < 32'sh0000_03E8)
    |=> code_ff == 16'(-$past(sig_mv)))
    else $error("unity gain path does not invert the signal");

  AST_OFFSET_ONLY: assert property (
    (sig_mv == 32'sh0000_0000 && signed'(offset) > 16'shFED4 &&
     signed'(offset) < 16'sh012C)
    |=> code_ff == 16'(32'(signed'($past(offset))) * 32'sh0000_0064))
    else $error("offset step is not 100 mV");

  AST_SATURATE_HIGH: assert property (
    (gain == `MON_GAIN_RESET && offset == `MON_OFS_RESET &&
     sig_mv <= 32'shFFFF_7FFF)
    |=> code_ff == 16'sh7FFF)
    else $error("positive overflow not clipped");

  AST_SATURATE_LOW: assert property (
    (gain == `MON_GAIN_RESET && offset == `MON_OFS_RESET &&
     sig_mv >= 32'sh0000_8001)
    ##1 (offset == `MON_OFS_RESET) |-> code_ff == 16'sh8000)
    else $error("negative overflow not clipped");

endmodule

`default_nettype wire

/* File: verification/monitor_recorder.sv */
`default_nettype none

module monitor_recorder (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Monitor connector levels
  input wire monitor_scaling_pkg::monitor_codes_type codes,
  // Last sampled levels, millivolts
  output logic signed [15:0] seen_one,
  output logic signed [15:0] seen_two
);
  timeunit 1ns;
  timeprecision 1ps;

  // Instrument samples both channels on every rising edge, never drives back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_one <= 16'h0000;
      seen_two <= 16'h0000;
    end else begin
      seen_one <= codes.ch_one;
      seen_two <= codes.ch_two;
    end
  end
endmodule

`default_nettype wire

/* File: verification/tb.sv */
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed, rd, e1, e2;
  logic [15:0] g1, g2, o1, o2;
  logic [7:0] s2;
  logic signed [15:0] seen_one, seen_two;
  logic [31:0] rst_exp [6];
  monitor_scaling_pkg::drive_quantities_type q;
  monitor_scaling_pkg::drive_quantities_type qc;
  monitor_scaling_pkg::monitor_codes_type codes;
  int err_count, num_checks;

  analog_monitor_scaling analog_monitor_scaling_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .quantities(q), .monitor_output_connector(codes));

  monitor_recorder monitor_recorder_i (
    .pclk(pclk), .presetn(presetn), .codes(codes), .seen_one(seen_one),
    .seen_two(seen_two));

  // Clock, 50 ns period
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Xorshift source, fixed start
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Random drive quantities, every field and mode
  function automatic monitor_scaling_pkg::drive_quantities_type rq();
    logic [191:0] w;
    w = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
    return w[$bits(monitor_scaling_pkg::drive_quantities_type)-1:0];
  endfunction

  // Scaled signal in millivolts for one selection
  function automatic longint exp_sig(input logic [7:0] s,
                                     input monitor_scaling_pkg::drive_quantities_type d);
    case (s)
      8'h00: return d.motor_speed;
      8'h01: return d.speed_ref;
      8'h02: return d.torque_ref;
      8'h03: return (d.control_mode === monitor_scaling_pkg::CTRL_POSITION) ?
                    50 * longint'(d.pos_deviation) : 0;
      8'h04: return 50 * longint'(d.amp_deviation);
      8'h05: return d.pos_cmd_speed;
      8'h07: return 10 * longint'(d.load_deviation);
      8'h08: return d.positioning_done ? 5000 : 0;
      8'h09: return d.speed_ff;
      8'h0A: return d.torque_ff;
      8'h0B: return d.second_gain_active ? 2000 : 1000;
      8'h0C: return d.distribution_done ? 5000 : 0;
      8'h0D: return d.ext_enc_speed;
      default: return 0;
    endcase
  endfunction

  // Negated, magnified, offset and saturated converter code
  function automatic logic [15:0] exp_code(input longint sig, input logic [15:0] g,
                                           input logic [15:0] o);
    longint r;
    r = -((sig * longint'($signed(g))) / 100) + longint'($signed(o)) * 100;
    if (r > 32767) r = 32767;
    if (r < -32768) r = -32768;
    return r[15:0];
  endfunction

  // Compare and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer, answer taken at the pready edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ends at the first access edge, pready is always high
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watchdog against a hung run
  initial begin
    repeat (8000) @(posedge pclk);
    err_count++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    q = '0;
    seed = 32'h0001_1C34;
    err_count = 0;
    num_checks = 0;
    rst_exp = '{32'h0000_0002, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
                32'h0000_0064, 32'h0000_0064};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values of the settings
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0000_0000);
      chk("reset_value", rd, rst_exp[i]);
      chk("reset_err", {31'h0, err}, 32'h0000_0000);
    end
    // Refused accesses
    apb(1'b1, 12'h018, 32'h0000_1234);
    chk("ro_write_err", {31'h0, err}, 32'h0000_0001);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk("unmapped_err", {31'h0, err}, 32'h0000_0001);
    chk("unmapped_data", rd, 32'h0000_0000);
    apb(1'b0, 12'h002, 32'h0000_0000);
    chk("unaligned_err", {31'h0, err}, 32'h0000_0001);
    // Out of range settings clamp to the limits
    apb(1'b1, 12'h010, 32'h0000_4E20);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("gain_clamp", rd, 32'h0000_2710);
    apb(1'b1, 12'h00C, 32'h0000_B1E0);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk("offset_clamp", rd, 32'h0000_D8F0);
    apb(1'b1, 12'h008, 32'h0000_4E20);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk("offset_clamp_high", rd, 32'h0000_2710);
    // Every selection code on both channels, unity gain on channel one, small gain on channel two, full gains on both
    for (int c = 0; c < 16; c++) begin
      for (int r = 0; r < 3; r++) begin
        g1 = (r == 0) ? 16'h0064 : 16'(int'(rnd() % 20001) - 10000);
        g2 = (r == 1) ? 16'(int'(rnd() % 201) - 100) : 16'(int'(rnd() % 20001) - 10000);
        o1 = (r == 0) ? 16'h0000 : 16'(int'(rnd() % 601) - 300);
        o2 = 16'(int'(rnd() % 601) - 300);
        s2 = 8'((c + 5) % 16);
        @(posedge pclk);
        q <= rq();
        apb(1'b1, 12'h000, 32'(c));
        apb(1'b1, 12'h004, {24'h00_0000, s2});
        apb(1'b1, 12'h010, {16'h0000, g1});
        apb(1'b1, 12'h014, {16'h0000, g2});
        apb(1'b1, 12'h008, {16'h0000, o1});
        apb(1'b1, 12'h00C, {16'h0000, o2});
        repeat (6) @(posedge pclk);
        @(negedge pclk);
        e1 = {16'h0000, exp_code(exp_sig(8'(c), q), g1, o1)};
        e2 = {16'h0000, exp_code(exp_sig(s2, q), g2, o2)};
        chk("ch_one", {16'h0000, seen_one}, e1);
        chk("ch_two", {16'h0000, seen_two}, e2);
        // Read-only code registers mirror the connector
        apb(1'b0, 12'h018, 32'h0000_0000);
        chk("code_one_read", rd, e1);
        apb(1'b0, 12'h01C, 32'h0000_0000);
        chk("code_two_read", rd, e2);
        chk("code_read_err", {31'h0, err}, 32'h0000_0000);
      end
    end
    // New offset shows within two cycles
    o1 = 16'h0005;
    apb(1'b1, 12'h008, {16'h0000, o1});
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    e1 = {16'h0000, exp_code(exp_sig(8'h0F, q), g1, o1)};
    chk("offset_now", {16'h0000, seen_one}, e1);
    // Mid-run reset clears codes and restores defaults
    @(posedge pclk);
    presetn <= 1'b0;
    q <= '0;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk("reset_codes", codes, 32'h0000_0000);
    qc = '0;
    qc.torque_ref = 16'sh0123;
    qc.motor_speed = 16'shFE00;
    @(posedge pclk);
    presetn <= 1'b1;
    q <= qc;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0000_0000);
      chk("rereset_value", rd, rst_exp[i]);
    end
    // Default selections at unity gain, small values
    @(negedge pclk);
    e1 = {16'h0000, exp_code(exp_sig(8'h02, qc), 16'h0064, 16'h0000)};
    e2 = {16'h0000, exp_code(exp_sig(8'h00, qc), 16'h0064, 16'h0000)};
    chk("unity_one", {16'h0000, seen_one}, e1);
    chk("unity_two", {16'h0000, seen_two}, e2);
    tally_and_finish();
  end
endmodule

`default_nettype wire
